// file: rtl/icm_pkg.sv
// Package: register map, bit layout and types of the interrupt mask gate
package icm_pkg;
    // ****************************************************************
    // Bus and field widths
    // ****************************************************************
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int THR_W = 10;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [AW-1:0] OFF_TX_THR = 8'h1C;
    localparam logic [AW-1:0] OFF_RX_THR = 8'h20;
    localparam logic [AW-1:0] OFF_MASK = 8'h2C;
    localparam logic [AW-1:0] OFF_RAW = 8'h30;
    localparam logic [AW-1:0] OFF_CLEAR = 8'h34;
    localparam logic [AW-1:0] OFF_MSTAT = 8'h38;
    // ****************************************************************
    // Source bit positions, shared by mask, raw, clear and masked status
    // ****************************************************************
    localparam int B_TXE = 0;
    localparam int B_TXL = 1;
    localparam int B_TXF = 2;
    localparam int B_TXO = 3;
    localparam int B_RXE = 4;
    localparam int B_RXH = 5;
    localparam int B_RXF = 6;
    localparam int B_SRR = 16;
    localparam int B_SRU = 17;
    localparam int B_SWR = 18;
    localparam int B_MDN = 19;
    localparam int B_SDN = 20;
    localparam int B_ARB = 24;
    localparam int B_BUS = 25;
    localparam int B_MNS = 28;
    // ****************************************************************
    // Reset values and field masks
    // ****************************************************************
    localparam logic [DW-1:0] MASK_VALID = 32'h131F_007F;
    localparam logic [DW-1:0] STICKY = 32'h131F_0008;
    localparam logic [DW-1:0] MASK_RST = 32'h0000_0000;
    localparam logic [6:0] LVL_RST = 7'h13;
    localparam logic [THR_W-1:0] THR_RST = 10'h000;
    localparam logic [THR_W-1:0] FIFO_DEPTH = 10'h010;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic slave_read_req;
        logic slave_read_underflow;
        logic slave_write_req;
        logic master_done;
        logic slave_done;
        logic arb_lost;
        logic bus_fault;
        logic master_done_nostop;
    } icm_evt_t;
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic [3:0] strb;
    } icm_wr_t;
    typedef enum logic {WS_IDLE = 1'b0, WS_RESP = 1'b1} icm_wst_t;
    // Byte-lane merge of write data into an old value
    function automatic logic [DW-1:0] icm_merge(input logic [DW-1:0] old,
        input logic [DW-1:0] d, input logic [3:0] s);
        logic [DW-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage

// file: rtl/icm_flag_bank.sv
// Bank of sticky flags: set by hardware, cleared by software, set wins
`timescale 1ns/1ps
module icm_flag_bank #(
    parameter int N = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    output logic [N-1:0] q
);
    genvar i;
    for (i = 0; i < N; i++) begin : g_bit
        logic flag_r;
        logic flag_nxt;
        always_comb begin
            flag_nxt = set[i] | (flag_r & ~clr[i]);
        end
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                flag_r <= 1'b0;
            end else if (ce) begin
                flag_r <= flag_nxt;
            end
        end
        assign q[i] = flag_r;
    end
endmodule

// file: rtl/icm_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
module icm_axil_slave
    import icm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    output logic arready,
    output logic [DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output icm_wr_t wr,
    output logic wr_en,
    input wire logic wr_err,
    input wire logic [DW-1:0] rd_data,
    input wire logic rd_err
);
    icm_wst_t ws_r, ws_nxt;
    logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
    icm_wr_t wr_r, wr_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [DW-1:0] rdata_r, rdata_nxt;

    always_comb begin
        ws_nxt = ws_r;
        aw_ok_nxt = aw_ok_r;
        w_ok_nxt = w_ok_r;
        wr_nxt = wr_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        awready = ce && (ws_r == WS_IDLE) && !aw_ok_r;
        wready = ce && (ws_r == WS_IDLE) && !w_ok_r;
        wr_en = ce && (ws_r == WS_IDLE) && aw_ok_r && w_ok_r;
        arready = ce && !rvalid_r;
        if (awvalid && awready) begin
            aw_ok_nxt = 1'b1;
            wr_nxt.addr = awaddr;
        end
        if (wvalid && wready) begin
            w_ok_nxt = 1'b1;
            wr_nxt.data = wdata;
            wr_nxt.strb = wstrb;
        end
        case (ws_r)
            WS_IDLE: begin
                if (wr_en) begin
                    ws_nxt = WS_RESP;
                    aw_ok_nxt = 1'b0;
                    w_ok_nxt = 1'b0;
                    bresp_nxt = wr_err ? RESP_ERR : RESP_OK;
                end
            end
            WS_RESP: begin
                if (bready) begin
                    ws_nxt = WS_IDLE;
                end
            end
            default: ws_nxt = WS_IDLE;
        endcase
        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_data;
            rresp_nxt = rd_err ? RESP_ERR : RESP_OK;
        end else if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ws_r <= WS_IDLE;
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            wr_r <= '0;
            bresp_r <= RESP_OK;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OK;
        end else if (ce) begin
            ws_r <= ws_nxt;
            aw_ok_r <= aw_ok_nxt;
            w_ok_r <= w_ok_nxt;
            wr_r <= wr_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign bvalid = (ws_r == WS_RESP);
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign wr = wr_r;
endmodule

// file: rtl/icm_mask_gate.sv
// Top: interrupt mask gate of a two-wire bus controller, AXI4-Lite port
`timescale 1ns/1ps
// ********************************************************************
// Overview of operation
// - Mask bit 0 passes the transmit-empty flag to the request.
// - Mask bit 1 passes the transmit-nearly-empty flag.
// - Mask bit 2 passes the transmit-full flag.
// - Mask bit 3 passes the transmit-overrun flag.
// - Mask bit 4 passes the receive-empty flag.
// - Mask bit 5 passes the receive-nearly-full flag.
// - Mask bit 6 passes the receive-full flag.
// - Mask bit 16 passes the slave read request flag.
// - Mask bit 17 passes the slave read underflow flag.
// - Mask bit 18 passes the slave write request flag.
// - Mask bit 19 passes the master transaction done flag.
// - Mask bit 20 passes the slave transaction done flag.
// - Mask bit 24 passes the arbitration lost flag.
// - Mask bit 25 passes the bus fault flag.
// - Mask bit 28 passes the master done without stop flag.
// - Transmit-empty flag is one while the FIFO is empty; resets to one.
// - Receive-nearly-full flag is one while count reaches the threshold.
// - Overrun flag sets on write to full FIFO; only clear register clears.
// ********************************************************************
module icm_mask_gate
    import icm_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic [AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [DW-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [DW-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [THR_W-1:0] TX_COUNT,
    input wire logic [THR_W-1:0] RX_COUNT,
    input wire logic TX_WRITE,
    input wire icm_evt_t EVENTS,
    output logic [THR_W-1:0] TX_THRESHOLD,
    output logic [THR_W-1:0] RX_THRESHOLD,
    output logic IRQ
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    icm_wr_t wr;
    logic wr_en, wr_err, rd_err;
    logic [DW-1:0] rd_data;
    logic [DW-1:0] mask_r, mask_nxt;
    logic [THR_W-1:0] tx_thr_r, tx_thr_nxt, rx_thr_r, rx_thr_nxt;
    logic [6:0] lvl_r, lvl_nxt;
    logic irq_r, irq_nxt;
    logic [DW-1:0] set_vec, clr_vec, sticky_q;
    logic [DW-1:0] raw_status, masked;
    logic tx_empty_flag, tx_low_level_flag, tx_full_flag;
    logic tx_overrun_flag, rx_empty_flag, rx_high_level_flag;
    logic rx_full_flag, slave_read_req_flag, slave_read_underflow_flag;
    logic slave_write_req_flag, master_done_flag, slave_done_flag;
    logic arb_lost_flag, bus_fault_flag, master_done_nostop_flag;
    logic tx_empty_enable, tx_low_level_enable, tx_full_enable;
    logic tx_overrun_enable, rx_empty_enable, rx_high_level_enable;
    logic rx_full_enable, slave_read_req_enable;
    logic slave_read_underflow_enable, slave_write_req_enable;
    logic master_done_enable, slave_done_enable, arb_lost_enable;
    logic bus_fault_enable, master_done_nostop_enable;

    // ****************************************************************
    // Register port
    // ****************************************************************
    icm_axil_slave u_bus (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .ce(CE),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr(wr),
        .wr_en(wr_en),
        .wr_err(wr_err),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ****************************************************************
    // Write decode and control registers
    // ****************************************************************
    always_comb begin
        mask_nxt = mask_r;
        tx_thr_nxt = tx_thr_r;
        rx_thr_nxt = rx_thr_r;
        clr_vec = '0;
        wr_err = 1'b0;
        if (wr.addr == OFF_MASK) begin
            if (wr_en) begin
                mask_nxt = icm_merge(mask_r, wr.data, wr.strb) & MASK_VALID;
            end
        end else if (wr.addr == OFF_TX_THR) begin
            if (wr_en) begin
                tx_thr_nxt = THR_W'(icm_merge(DW'(tx_thr_r), wr.data,
                    wr.strb));
            end
        end else if (wr.addr == OFF_RX_THR) begin
            if (wr_en) begin
                rx_thr_nxt = THR_W'(icm_merge(DW'(rx_thr_r), wr.data,
                    wr.strb));
            end
        end else if (wr.addr == OFF_CLEAR) begin
            // clear register reaches sticky flags only
            if (wr_en) begin
                clr_vec = icm_merge('0, wr.data, wr.strb) & STICKY;
            end
        end else if (wr.addr == OFF_RAW || wr.addr == OFF_MSTAT) begin
            wr_err = 1'b0;
        end else begin
            wr_err = 1'b1;
        end
    end

    // ****************************************************************
    // Read decode
    // ****************************************************************
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        if (S_AXI_ARADDR == OFF_MASK) begin
            rd_data = mask_r;
        end else if (S_AXI_ARADDR == OFF_TX_THR) begin
            rd_data = DW'(tx_thr_r);
        end else if (S_AXI_ARADDR == OFF_RX_THR) begin
            rd_data = DW'(rx_thr_r);
        end else if (S_AXI_ARADDR == OFF_RAW) begin
            rd_data = raw_status;
        end else if (S_AXI_ARADDR == OFF_MSTAT) begin
            rd_data = masked;
        end else if (S_AXI_ARADDR == OFF_CLEAR) begin
            rd_data = '0;
        end else begin
            rd_err = 1'b1;
        end
    end

    // ****************************************************************
    // FIFO level flags
    // ****************************************************************
    always_comb begin
        lvl_nxt = lvl_r;
        lvl_nxt[B_TXE] = (TX_COUNT == '0);
        lvl_nxt[B_TXL] = (TX_COUNT <= tx_thr_r);
        lvl_nxt[B_TXF] = (TX_COUNT == FIFO_DEPTH);
        lvl_nxt[B_TXO] = 1'b0;
        lvl_nxt[B_RXE] = (RX_COUNT == '0);
        // nearly full at or above threshold
        lvl_nxt[B_RXH] = (RX_COUNT >= rx_thr_r);
        lvl_nxt[B_RXF] = (RX_COUNT == FIFO_DEPTH);
    end

    // ****************************************************************
    // Sticky event flags
    // ****************************************************************
    always_comb begin
        set_vec = '0;
        // overrun on write into a full FIFO
        set_vec[B_TXO] = TX_WRITE && tx_full_flag;
        set_vec[B_SRR] = EVENTS.slave_read_req;
        set_vec[B_SRU] = EVENTS.slave_read_underflow;
        set_vec[B_SWR] = EVENTS.slave_write_req;
        set_vec[B_MDN] = EVENTS.master_done;
        set_vec[B_SDN] = EVENTS.slave_done;
        set_vec[B_ARB] = EVENTS.arb_lost;
        set_vec[B_BUS] = EVENTS.bus_fault;
        set_vec[B_MNS] = EVENTS.master_done_nostop;
    end

    icm_flag_bank #(.N(DW)) u_flags (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .ce(CE),
        .set(set_vec),
        .clr(clr_vec),
        .q(sticky_q)
    );

    assign tx_empty_flag = lvl_r[B_TXE];
    assign tx_low_level_flag = lvl_r[B_TXL];
    assign tx_full_flag = lvl_r[B_TXF];
    assign tx_overrun_flag = sticky_q[B_TXO];
    assign rx_empty_flag = lvl_r[B_RXE];
    assign rx_high_level_flag = lvl_r[B_RXH];
    assign rx_full_flag = lvl_r[B_RXF];
    assign slave_read_req_flag = sticky_q[B_SRR];
    assign slave_read_underflow_flag = sticky_q[B_SRU];
    assign slave_write_req_flag = sticky_q[B_SWR];
    assign master_done_flag = sticky_q[B_MDN];
    assign slave_done_flag = sticky_q[B_SDN];
    assign arb_lost_flag = sticky_q[B_ARB];
    assign bus_fault_flag = sticky_q[B_BUS];
    assign master_done_nostop_flag = sticky_q[B_MNS];

    always_comb begin
        raw_status = '0;
        raw_status[6:0] = lvl_r;
        raw_status = raw_status | (sticky_q & STICKY);
    end

    // ****************************************************************
    // Enable fields
    // ****************************************************************
    // transmit empty enable
    assign tx_empty_enable = mask_r[B_TXE];
    assign tx_low_level_enable = mask_r[B_TXL];
    assign tx_full_enable = mask_r[B_TXF];
    assign tx_overrun_enable = mask_r[B_TXO];
    assign rx_empty_enable = mask_r[B_RXE];
    assign rx_high_level_enable = mask_r[B_RXH];
    assign rx_full_enable = mask_r[B_RXF];
    assign slave_read_req_enable = mask_r[B_SRR];
    assign slave_read_underflow_enable = mask_r[B_SRU];
    assign slave_write_req_enable = mask_r[B_SWR];
    assign master_done_enable = mask_r[B_MDN];
    assign slave_done_enable = mask_r[B_SDN];
    assign arb_lost_enable = mask_r[B_ARB];
    assign bus_fault_enable = mask_r[B_BUS];
    assign master_done_nostop_enable = mask_r[B_MNS];

    // ****************************************************************
    // Gating and request
    // ****************************************************************
    always_comb begin
        masked = '0;
        masked[B_TXE] = tx_empty_flag & tx_empty_enable;
        masked[B_TXL] = tx_low_level_flag & tx_low_level_enable;
        masked[B_TXF] = tx_full_flag & tx_full_enable;
        masked[B_TXO] = tx_overrun_flag & tx_overrun_enable;
        masked[B_RXE] = rx_empty_flag & rx_empty_enable;
        masked[B_RXH] = rx_high_level_flag & rx_high_level_enable;
        masked[B_RXF] = rx_full_flag & rx_full_enable;
        masked[B_SRR] = slave_read_req_flag & slave_read_req_enable;
        masked[B_SRU] = slave_read_underflow_flag &
            slave_read_underflow_enable;
        masked[B_SWR] = slave_write_req_flag & slave_write_req_enable;
        masked[B_MDN] = master_done_flag & master_done_enable;
        masked[B_SDN] = slave_done_flag & slave_done_enable;
        masked[B_ARB] = arb_lost_flag & arb_lost_enable;
        masked[B_BUS] = bus_fault_flag & bus_fault_enable;
        masked[B_MNS] = master_done_nostop_flag & master_done_nostop_enable;
        irq_nxt = |masked;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            mask_r <= MASK_RST;
            tx_thr_r <= THR_RST;
            rx_thr_r <= THR_RST;
            lvl_r <= LVL_RST;
            irq_r <= 1'b0;
        end else if (CE) begin
            mask_r <= mask_nxt;
            tx_thr_r <= tx_thr_nxt;
            rx_thr_r <= rx_thr_nxt;
            lvl_r <= lvl_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign IRQ = irq_r;
    assign TX_THRESHOLD = tx_thr_r;
    assign RX_THRESHOLD = rx_thr_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_tx_empty_gate: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE && tx_empty_flag && tx_empty_enable |=> IRQ)
        else $error("Enabled transmit-empty flag did not raise request");
    a_overrun_gate: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE && tx_overrun_flag && mask_r[B_TXO] |=> IRQ)
        else $error("Enabled overrun flag did not raise request");
    a_slave_read_gate: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE && EVENTS.slave_read_req ##1 CE && slave_read_req_enable
        |=> IRQ)
        else $error("Enabled slave read request did not reach request");
    a_arb_lost_gate: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE && arb_lost_flag && !arb_lost_enable
        && (raw_status & mask_r) == '0 |=> !IRQ)
        else $error("Disabled arbitration lost flag raised request");
    a_nostop_gate: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE && master_done_nostop_flag && mask_r[B_MNS] |=> IRQ)
        else $error("Enabled no-stop done flag did not raise request");
    a_tx_empty_level: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE |=> tx_empty_flag == ($past(TX_COUNT) == '0))
        else $error("Transmit empty flag does not follow FIFO count");
    a_rx_high_level: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE |=> rx_high_level_flag == ($past(RX_COUNT) >= $past(rx_thr_r)))
        else $error("Receive nearly full flag does not follow threshold");
    a_overrun_hold: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE && tx_overrun_flag && !(wr_en && wr.addr == OFF_CLEAR)
        |=> tx_overrun_flag)
        else $error("Overrun flag dropped without a clear write");
    a_irq_or_gate: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        CE |=> IRQ == |($past(raw_status) & $past(mask_r)))
        else $error("Request differs from OR of gated flags");
    a_mask_reserved: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        (mask_r & ~MASK_VALID) == '0)
        else $error("Reserved mask bit became set");
endmodule

// file: testbench/icm_mask_gate_tb.sv
// Self-checking testbench of the interrupt mask gate
`timescale 1ns/1ps
module icm_mask_gate_tb
    import icm_pkg::*;
    ;
    typedef struct packed {
        logic [THR_W-1:0] c;
        logic [4:0] b;
        logic q;
    } icm_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [AW-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, tx_write = 1'b0;
    logic ce = 1'b1;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, br;
    logic [THR_W-1:0] tx_thr, rx_thr;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] rresp, r;
    logic [DW-1:0] wdata = 32'h0000_0000, rdata, d;
    logic [THR_W-1:0] tx_count = 10'h000, rx_count = 10'h000;
    icm_evt_t events = 8'h00;
    int errors = 0, n_checks = 0;
    icm_row_t rows [22] = '{
        '{10'h000, 5'h00, 1'b1}, '{10'h010, 5'h00, 1'b0},
        '{10'h000, 5'h01, 1'b1}, '{10'h010, 5'h01, 1'b0},
        '{10'h010, 5'h02, 1'b1}, '{10'h000, 5'h02, 1'b0},
        '{10'h000, 5'h03, 1'b1}, '{10'h000, 5'h04, 1'b1},
        '{10'h010, 5'h04, 1'b0}, '{10'h010, 5'h05, 1'b1},
        '{10'h010, 5'h06, 1'b1}, '{10'h000, 5'h06, 1'b0},
        '{10'h000, 5'h10, 1'b1}, '{10'h000, 5'h11, 1'b1},
        '{10'h000, 5'h12, 1'b1}, '{10'h000, 5'h13, 1'b1},
        '{10'h000, 5'h14, 1'b1}, '{10'h000, 5'h18, 1'b1},
        '{10'h000, 5'h19, 1'b1}, '{10'h000, 5'h1C, 1'b1},
        '{10'h000, 5'h07, 1'b0}, '{10'h000, 5'h1F, 1'b0}
    };
    always #2.5 clk = ~clk;
    icm_mask_gate dut_u (.REF_CLK(clk), .RESET_N(rst_n), .CE(ce),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TX_COUNT(tx_count),
        .RX_COUNT(rx_count), .TX_WRITE(tx_write), .EVENTS(events),
        .TX_THRESHOLD(tx_thr), .RX_THRESHOLD(rx_thr), .IRQ(irq));
    // ****************************************************************
    // Bus tasks and checks
    // ****************************************************************
    task wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = awready; tw = wready; tb = bvalid;
            br = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task rd(input logic [AW-1:0] a);
        logic ta, tv;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        tv = 1'b0;
        while (!tv) begin
            @(negedge clk);
            ta = arready; tv = rvalid; d = rdata; r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task summarize();
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_MASK);
        chk("mask", 32'h0, d);
        rd(OFF_RAW);
        chk("raw_b0", 32'h1, d & 32'h1);
        wr(OFF_MASK, 32'hFFFF_FFFF);
        chk("bresp_ok", {30'h0, RESP_OK}, {30'h0, br});
        rd(OFF_MASK);
        chk("mask_rsv", MASK_VALID, d);
        tx_count <= FIFO_DEPTH;
        repeat (2) @(posedge clk);
        tx_write <= 1'b1; events <= 8'hFF;
        @(posedge clk);
        tx_write <= 1'b0; events <= 8'h00;
        for (int i = 0; i < 22; i++) begin
            @(posedge clk);
            tx_count <= rows[i].c; rx_count <= rows[i].c;
            wr(OFF_MASK, 32'h1 << rows[i].b);
            repeat (3) @(negedge clk);
            chk("irq", {31'h0, rows[i].q}, {31'h0, irq});
        end
        rd(OFF_RAW);
        chk("raw", 32'h131F_003B, d);
        wr(OFF_CLEAR, 32'h0000_0008);
        rd(OFF_RAW);
        chk("raw_clr", 32'h131F_0033, d);
        wr(OFF_RX_THR, 32'h5);
        wr(OFF_TX_THR, 32'h0000_0403);
        chk("rx_thr", 32'h5, DW'(rx_thr));
        chk("tx_thr", 32'h3, DW'(tx_thr));
        wr(OFF_MASK, 32'h20);
        rx_count <= 10'h004;
        repeat (3) @(negedge clk);
        chk("irq_thr", 32'h0, {31'h0, irq});
        @(posedge clk);
        rx_count <= 10'h005;
        repeat (3) @(negedge clk);
        chk("irq_thr", 32'h1, {31'h0, irq});
        // Clock enable low freezes the flags and the request
        @(posedge clk);
        ce <= 1'b0;
        rx_count <= 10'h004;
        repeat (3) @(negedge clk);
        chk("irq_ce_off", 32'h1, {31'h0, irq});
        @(posedge clk);
        ce <= 1'b1;
        repeat (3) @(negedge clk);
        chk("irq_ce_on", 32'h0, {31'h0, irq});
        @(posedge clk);
        wstrb <= 4'h1;
        wr(OFF_MASK, 32'hFFFF_FFFF);
        wstrb <= 4'hF;
        rd(OFF_MASK);
        chk("mask_strb", 32'h0000_007F, d);
        wr(8'h3C, 32'h1);
        chk("bresp_err", {30'h0, RESP_ERR}, {30'h0, br});
        rd(8'h3C);
        chk("rresp", {30'h0, RESP_ERR}, {30'h0, r});
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_MASK);
        chk("mask_rst2", 32'h0, d);
        chk("irq_rst2", 32'h0, {31'h0, irq});
        chk("rx_thr_rst2", 32'h0, DW'(rx_thr));
        summarize();
    end
endmodule
